// [fault_panel_model.sv]
// Behavioural model of the transmitter side: fault detectors, pushbuttons and contactor.
// Assumes the bench calls its tasks from one process and samples at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "recycle_cfg.svh"

module fault_panel_model (
   // Clock.
   input  wire logic                  clk_sys_in,
   // Contactor coil drive from the controller.
   input  wire logic                  hv_enable_in,
   // Detector lines and operator buttons toward the controller.
   output logic [`NUM_FAULTS-1:0]     fault_out,
   output logic                       plate_reset_out,
   output logic                       start_out,
   output logic                       lamp_preset_out
);
   // Contactor state as seen from the far side.
   logic contactor_closed;

   // Panel starts idle, with no fault and no button held.
   initial begin
      fault_out = 4'h0;
      plate_reset_out = 1'h0;
      start_out = 1'h0;
      lamp_preset_out = 1'h0;
   end

   // The contactor simply follows its coil drive.
   always @(negedge clk_sys_in) contactor_closed <= hv_enable_in;

   // Detector lines move only at the falling edge, away from the sampling edge.
   task automatic set_faults(input logic [`NUM_FAULTS-1:0] f);
      @(negedge clk_sys_in);
      fault_out = f;
   endtask

   // Buttons are set as a group: bit 0 reset, bit 1 start, bit 2 preset.
   task automatic set_buttons(input logic [2:0] b);
      @(negedge clk_sys_in);
      plate_reset_out = b[0];
      start_out = b[1];
      lamp_preset_out = b[2];
   endtask
endmodule
`default_nettype wire

// [overload_recycle.sv]
// Overload recycle controller: watches four fault lines, cycles high voltage off for an
// interval, counts faults in a window, locks out after three, and latches fault lamps.
// Assumes asynchronous fault and pushbutton pins and a free-running 40 MHz clock.
//
// Behaviour
// - Four fault lines; any one asserted is an overload.
// - Overload drops high voltage for two seconds; first fault starts sixty-second window.
// - High voltage returns after off period; a later fault repeats the cycle.
// - Fault still present at off end keeps voltage off and counts again.
// - Three faults in one window lock out high voltage with no retries.
// - Window expiring with two or fewer faults clears count and idles.
// - A single fault recovers automatically after the off period.
// - Lockout leaves only on a reset or start button edge after fault removal; count cleared.
// - One lamp per fault source, held lit until a reset clears it.
// - Start command clears the fault count and all lamps.
// - Lamp latch sets on the rising edge of its fault.
// - Lamp clear dominates; clear low blocks setting; preset forces lamp on.
// - Fault count advances once per occurrence; two bits suffice to see three.
// - Active-high count reset forces zero and blocks counting.
// - Timers fire on the documented trigger edge combinations.
// - Timers are non-retriggerable until their interval completes.
`timescale 1ns/1ps
`default_nettype none
`include "recycle_cfg.svh"

module overload_recycle (
   // Clock and reset.
   input  wire logic                    clk_sys_in,
   input  wire logic                    nrst_in,
   // Fault detector lines, active high.
   input  wire logic [`NUM_FAULTS-1:0]  fault_in,
   // Operator pushbuttons, active high.
   input  wire logic                    plate_reset_in,
   input  wire logic                    start_in,
   // Lamp test preset, active high.
   input  wire logic                    lamp_preset_in,
   // High-voltage contactor enable and indications.
   output logic                         hv_enable_out,
   output logic [`NUM_FAULTS-1:0]       lamp_out,
   output logic                         lockout_out,
   output logic [1:0]                   fault_count_out
);

   localparam int NS = `NUM_FAULTS + 3;

   // Three-stage synchronisers; a change counts once stages two and three agree.
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [NS-1:0] s3_q;
   logic [NS-1:0] clean_q;
   logic [NS-1:0] clean_prev_q;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= {lamp_preset_in, start_in, plate_reset_in, fault_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Filtered levels change only where stages agree, then get a one-cycle history.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clean_q      <= '0;
         clean_prev_q <= '0;
      end else begin
         for (int i = 0; i < NS; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               clean_q[i] <= s3_q[i];
            end
         end
         clean_prev_q <= clean_q;
      end
   end

   logic [`NUM_FAULTS-1:0] fault_lvl;
   logic [`NUM_FAULTS-1:0] fault_rise;
   logic                   reset_rise;
   logic                   start_rise;
   logic                   preset_lvl;
   logic                   overload;

   // Edge detection on filtered levels.
   assign fault_lvl  = clean_q[`NUM_FAULTS-1:0];
   assign fault_rise = clean_q[`NUM_FAULTS-1:0] & ~clean_prev_q[`NUM_FAULTS-1:0];
   assign reset_rise = clean_q[`NUM_FAULTS] & ~clean_prev_q[`NUM_FAULTS];
   assign start_rise = clean_q[`NUM_FAULTS+1] & ~clean_prev_q[`NUM_FAULTS+1];
   assign preset_lvl = clean_q[`NUM_FAULTS+2];
   assign overload   = |fault_lvl;

   // Lamp latches: clear is active low and wins, preset forces on, fault edge sets.
   logic lamp_clr_n;
   assign lamp_clr_n = ~(reset_rise | start_rise);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lamp_out <= '0;
      end else begin
         for (int i = 0; i < `NUM_FAULTS; i++) begin
            if (!lamp_clr_n) begin
               lamp_out[i] <= 1'b0;
            end else if (preset_lvl) begin
               lamp_out[i] <= 1'b1;
            end else if (fault_rise[i]) begin
               lamp_out[i] <= 1'b1;
            end
         end
      end
   end

   // Sequencer state and timers.
   recycle_pkg::seq_state_t state_q;
   logic [`TIMER_W-1:0]     off_cnt_q;
   logic [`TIMER_W-1:0]     win_cnt_q;
   logic                    win_run_q;
   logic                    off_done;
   logic                    win_done;
   logic                    count_pulse;
   logic                    count_reset;
   logic                    off_fire;

   assign off_done = (state_q == recycle_pkg::ST_OFF) && (off_cnt_q == '0);
   assign win_done = win_run_q && (win_cnt_q == '0);

   // Occurrence: a new overload while running, or a fault persisting at the off end.
   assign off_fire    = (state_q == recycle_pkg::ST_IDLE || state_q == recycle_pkg::ST_RUN)
                        && overload;
   assign count_pulse = off_fire || (off_done && overload);
   assign count_reset = start_rise
                        || (reset_rise && state_q == recycle_pkg::ST_LOCKOUT && !overload)
                        || (win_done && state_q != recycle_pkg::ST_LOCKOUT);

   // Fault counter, two bits.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fault_count_out <= 2'h0;
      end else if (count_reset) begin
         fault_count_out <= 2'h0;
      end else if (count_pulse && fault_count_out != `LOCKOUT_COUNT) begin
         fault_count_out <= fault_count_out + 2'h1;
      end
   end

   // Off-period one-shot; loads only when fired, ignores triggers while counting.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         off_cnt_q <= '0;
      end else if (off_fire || (off_done && overload)) begin
         off_cnt_q <= `TIMER_W'(`OFF_CYCLES - 1);
      end else if (state_q == recycle_pkg::ST_OFF && off_cnt_q != '0) begin
         off_cnt_q <= off_cnt_q - `TIMER_W'(1);
      end
   end

   // Window one-shot; started by the first fault, not retriggered while running.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         win_run_q <= 1'b0;
         win_cnt_q <= '0;
      end else if (count_reset) begin
         win_run_q <= 1'b0;
         win_cnt_q <= '0;
      end else if (count_pulse && !win_run_q) begin
         win_run_q <= 1'b1;
         win_cnt_q <= `TIMER_W'(`WINDOW_CYCLES - 1);
      end else if (win_run_q && win_cnt_q != '0) begin
         win_cnt_q <= win_cnt_q - `TIMER_W'(1);
      end
   end

   // Sequencer.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= recycle_pkg::ST_IDLE;
      end else begin
         case (state_q)
            recycle_pkg::ST_IDLE, recycle_pkg::ST_RUN: begin
               if (overload) begin
                  if (fault_count_out == 2'h2) begin
                     state_q <= recycle_pkg::ST_LOCKOUT;
                  end else begin
                     state_q <= recycle_pkg::ST_OFF;
                  end
               end else if (win_done || start_rise) begin
                  state_q <= recycle_pkg::ST_IDLE;
               end
            end
            recycle_pkg::ST_OFF: begin
               if (start_rise) begin
                  state_q <= recycle_pkg::ST_IDLE;
               end else if (off_done) begin
                  if (!overload) begin
                     state_q <= win_run_q ? recycle_pkg::ST_RUN
                                          : recycle_pkg::ST_IDLE;
                  end else if (fault_count_out == 2'h2) begin
                     state_q <= recycle_pkg::ST_LOCKOUT;
                  end
               end
            end
            recycle_pkg::ST_LOCKOUT: begin
               if ((reset_rise || start_rise) && !overload) begin
                  state_q <= recycle_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= recycle_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // High voltage enabled only while no overload path is active.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hv_enable_out <= 1'b0;
         lockout_out   <= 1'b0;
      end else begin
         hv_enable_out <= (state_q == recycle_pkg::ST_IDLE || state_q == recycle_pkg::ST_RUN)
                          && !overload;
         lockout_out   <= (state_q == recycle_pkg::ST_LOCKOUT);
      end
   end

   // Assertions.
   property p_lock_hv_off;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         state_q == recycle_pkg::ST_LOCKOUT |=> !hv_enable_out;
   endproperty
   a_lock_hv_off: assert property (p_lock_hv_off) else $error("HV on in lockout.");

   property p_overload_drops;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         overload |=> !hv_enable_out;
   endproperty
   a_overload_drops: assert property (p_overload_drops) else $error("HV not dropped.");

   property p_lamp_hold;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         lamp_out[0] && lamp_clr_n |=> lamp_out[0];
   endproperty
   a_lamp_hold: assert property (p_lamp_hold) else $error("Lamp lost.");

   property p_lamp_set;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         fault_rise[1] && lamp_clr_n |=> lamp_out[1];
   endproperty
   a_lamp_set: assert property (p_lamp_set) else $error("Lamp not set.");

   property p_clear_wins;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         !lamp_clr_n |=> lamp_out == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins) else $error("Lamp clear lost.");

   property p_start_clears;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         start_rise |=> fault_count_out == 2'h0;
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("Count kept.");

   property p_count_step;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         count_pulse && !count_reset && fault_count_out == 2'h0 |=> fault_count_out == 2'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("Count no step.");

   sequence s_off_entry;
      state_q != recycle_pkg::ST_OFF ##1 state_q == recycle_pkg::ST_OFF;
   endsequence
   property p_off_loaded;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         s_off_entry |-> off_cnt_q == `TIMER_W'(`OFF_CYCLES - 1);
   endproperty
   a_off_loaded: assert property (p_off_loaded) else $error("Off timer bad.");

   // The lockout lamp follows the lockout state one edge later.
   property p_lockout_flag;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         state_q == recycle_pkg::ST_LOCKOUT |=> lockout_out;
   endproperty
   a_lockout_flag: assert property (p_lockout_flag) else $error("Lockout flag missing.");

   // Lockout holds until a button edge arrives with every fault gone.
   property p_lock_holds;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         state_q == recycle_pkg::ST_LOCKOUT && !((reset_rise || start_rise) && !overload)
         |=> state_q == recycle_pkg::ST_LOCKOUT;
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("Lockout left early.");

   // A new overload with two occurrences already counted ends in lockout.
   property p_third_locks;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         off_fire && fault_count_out == 2'h2 |=> state_q == recycle_pkg::ST_LOCKOUT;
   endproperty
   a_third_locks: assert property (p_third_locks) else $error("Third fault no lockout.");

   // A window that runs out short of lockout leaves the count at zero.
   property p_window_clears;
      @(posedge clk_sys_in) disable iff (!nrst_in)
         win_done && state_q != recycle_pkg::ST_LOCKOUT |=> fault_count_out == 2'h0;
   endproperty
   a_window_clears: assert property (p_window_clears) else $error("Window kept count.");

endmodule

`default_nettype wire

// [overload_recycle_tb.sv]
// Self-checking bench for the overload recycle controller.
// Assumes the full-length off period, so only the early part of each cycle is reached.
`timescale 1ns/1ps
`default_nettype none
`include "recycle_cfg.svh"

module overload_recycle_tb;
   logic        clk_sys_in = 1'h0;
   logic        nrst_in = 1'h0;
   logic [3:0]  fault_w;
   logic        plate_reset_w;
   logic        start_w;
   logic        preset_w;
   logic        hv_enable_out;
   logic [3:0]  lamp_out;
   logic        lockout_out;
   logic [1:0]  fault_count_out;
   int          mismatches = 0;
   int          checks_done = 0;
   int          exp_hv;
   int          exp_lamps;
   int          occ_q[$];
   int          pat;

   overload_recycle overload_recycle_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .fault_in(fault_w), .plate_reset_in(plate_reset_w), .start_in(start_w),
      .lamp_preset_in(preset_w), .hv_enable_out(hv_enable_out), .lamp_out(lamp_out),
      .lockout_out(lockout_out), .fault_count_out(fault_count_out));

   fault_panel_model fault_panel_model_inst (.clk_sys_in(clk_sys_in),
      .hv_enable_in(hv_enable_out), .fault_out(fault_w), .plate_reset_out(plate_reset_w),
      .start_out(start_w), .lamp_preset_out(preset_w));

   // Clock at 40 MHz.
   always #12.5 clk_sys_in = ~clk_sys_in;

   // Shared mismatch report.
   task automatic report(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_hv(input logic got, input logic exp);
      report({3'h0, got}, {3'h0, exp});
   endtask
   task automatic check_lamps(input logic [3:0] got, input logic [3:0] exp);
      report(got, exp);
   endtask
   task automatic check_count(input logic [1:0] got, input logic [1:0] exp);
      report({2'h0, got}, {2'h0, exp});
   endtask

   // Compares every output with the model.
   task automatic check_all();
      check_hv(hv_enable_out, exp_hv[0]);
      check_hv(lockout_out, 1'h0);
      check_lamps(lamp_out, exp_lamps[3:0]);
      check_count(fault_count_out, 2'(occ_q.size()));
      check_hv(fault_panel_model_inst.contactor_closed, exp_hv[0]);
   endtask

   // Resets the design and the model, then checks the idle state.
   task automatic do_reset(input int n);
      @(negedge clk_sys_in);
      nrst_in = 1'h0;
      exp_hv = 0;
      exp_lamps = 0;
      occ_q.delete();
      repeat (n) @(negedge clk_sys_in);
      check_all();
      nrst_in = 1'h1;
      repeat (10) @(negedge clk_sys_in);
      exp_hv = 1;
      check_all();
   endtask

   // Raises a fault pattern and waits, bounded, for high voltage to drop.
   task automatic apply(input logic [3:0] f);
      int k;
      fault_panel_model_inst.set_faults(f);
      for (k = 0; k < 20 && hv_enable_out !== 1'h0; k++) @(negedge clk_sys_in);
      // Lamps of new sources need the full synchroniser delay even when HV is already off.
      repeat (8) @(negedge clk_sys_in);
      if (exp_hv == 1) occ_q.push_back(1);
      exp_hv = 0;
      exp_lamps = exp_lamps | f;
      check_all();
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main test sequence.
   initial begin
      void'($urandom(25145));
      do_reset(16);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         do_reset(2);
         apply(4'h1 << i);
         fault_panel_model_inst.set_faults(4'h0);
         repeat (10) @(negedge clk_sys_in);
         check_all();
      end
      $display("test single sources done");
      do_reset(2);
      pat = $urandom_range(15, 1);
      apply(pat[3:0]);
      fault_panel_model_inst.set_faults(4'h0);
      pat = $urandom_range(15, 1);
      apply(pat[3:0]);
      fault_panel_model_inst.set_faults(4'h0);
      repeat (10) @(negedge clk_sys_in);
      check_all();
      $display("test random patterns done");
      fault_panel_model_inst.set_buttons(3'h2);
      repeat (10) @(negedge clk_sys_in);
      fault_panel_model_inst.set_buttons(3'h0);
      exp_lamps = 0;
      occ_q.delete();
      exp_hv = 1;
      check_lamps(lamp_out, 4'h0);
      check_count(fault_count_out, 2'h0);
      check_all();
      $display("test start done");
      apply(4'h3);
      fault_panel_model_inst.set_faults(4'h0);
      repeat (10) @(negedge clk_sys_in);
      fault_panel_model_inst.set_buttons(3'h1);
      repeat (10) @(negedge clk_sys_in);
      fault_panel_model_inst.set_buttons(3'h0);
      exp_lamps = 0;
      check_lamps(lamp_out, 4'h0);
      check_all();
      $display("test plate reset done");
      fault_panel_model_inst.set_buttons(3'h4);
      repeat (10) @(negedge clk_sys_in);
      check_lamps(lamp_out, 4'hf);
      fault_panel_model_inst.set_buttons(3'h0);
      $display("test preset done");
      end_sim();
   end

   // Watchdog, well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      mismatches++;
      end_sim();
   end
endmodule
`default_nettype wire

// [recycle_cfg.svh]
// Timing and layout constants for the overload recycle controller.
// Assumes a 40 MHz system clock; included by the package and the design.
`ifndef RECYCLE_CFG_SVH
`define RECYCLE_CFG_SVH

`define CLK_HZ            40000000
`define OFF_TIME_MS       2000
`define WINDOW_TIME_MS    60000
// Cycle counts are worked out in 64 bits so the window product cannot overflow.
`define OFF_CYCLES        ((64'(`CLK_HZ) / 64'h3e8) * 64'(`OFF_TIME_MS))
`define WINDOW_CYCLES     ((64'(`CLK_HZ) / 64'h3e8) * 64'(`WINDOW_TIME_MS))
`define NUM_FAULTS        4
`define FAULT_DRV_CATH    0
`define FAULT_PA_CATH     1
`define FAULT_HV_SUPPLY   2
`define FAULT_REFLECTED   3
`define LOCKOUT_COUNT     2'h3
`define TIMER_W           32

`endif

// [recycle_pkg.sv]
// Types for the overload recycle controller.
// Assumes the constants header is on the include path.
`include "recycle_cfg.svh"

package recycle_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_OFF,
      ST_LOCKOUT
   } seq_state_t;
endpackage
